// [verilog/sdbt_pkg.sv]
// constants and types for the card block-transfer host sequencer
package sdbt_pkg;

  localparam logic [31:0] OFF_ST0     = 32'h0000_0008;
  localparam logic [31:0] OFF_IM      = 32'h0000_0010;
  localparam logic [31:0] OFF_BLEN    = 32'h0000_001C;
  localparam logic [31:0] OFF_NBLK    = 32'h0000_0020;
  localparam logic [31:0] OFF_DRR     = 32'h0000_0028;
  localparam logic [31:0] OFF_DXR     = 32'h0000_002C;
  localparam logic [31:0] OFF_CMD     = 32'h0000_0030;
  localparam logic [31:0] OFF_ARG     = 32'h0000_0034;
  localparam logic [31:0] OFF_FIFOCTL = 32'h0000_0074;

  // field positions inside the device registers
  localparam int FC_CLEAR_BIT  = 0;
  localparam int FC_DIR_BIT    = 1;
  localparam int FC_THR_BIT    = 2;
  localparam int FC_WIDTH_LSB  = 3;
  localparam int ST_DONE_BIT   = 0;
  localparam int ST_WRITE_CRC_ERROR_FLAG_BIT  = 5;
  localparam int ST_TXRDY_BIT  = 9;
  localparam int ST_RXRDY_BIT  = 10;
  localparam int ST_EMPTY_BIT  = 11;
  localparam int CMD_DMA_BIT   = 16;
  localparam int ARG_HIGH_LSB  = 16;

  localparam logic [31:0] BLOCK_BYTES   = 32'h0000_0200;
  localparam int          BLK_WORD_SHIFT = 7;
  localparam logic [3:0]  PRELOAD_WORDS = 4'h8;
  localparam logic [3:0]  CHUNK16_WORDS = 4'h4;
  localparam logic [3:0]  CHUNK32_WORDS = 4'h8;
  localparam logic [31:0] STOP_CMD_WORD = 32'h0000_000C;

  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CLR  = 4'b0001,
    S_CFG  = 4'b0010,
    S_BLEN = 4'b0011,
    S_NBLK = 4'b0100,
    S_IM   = 4'b0101,
    S_ARG  = 4'b0110,
    S_PRE  = 4'b0111,
    S_CMD  = 4'b1000,
    S_POLL = 4'b1001,
    S_XFER = 4'b1010,
    S_STOP = 4'b1011,
    S_FIN  = 4'b1100
  } sdbt_state_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10
  } sdbt_phase_t;

endpackage

// [verilog/sdbt_host.sv]
// host sequencer that runs block transfers on the card controller over ahb
//
// Design decisions made here: the AHB-Lite master port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sdbt_host #(
  parameter int BLK_CNT_W = 16
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic                 start,
  input  wire logic                 cfg_write,
  input  wire logic                 cfg_dma,
  input  wire logic                 cfg_threshold,
  input  wire logic [1:0]           cfg_width,
  input  wire logic                 cfg_auto_count,
  input  wire logic [BLK_CNT_W-1:0] cfg_blocks,
  input  wire logic [31:0]          cfg_command,
  input  wire logic [15:0]          arg_high,
  input  wire logic [15:0]          arg_low,
  input  wire logic [31:0]          tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  output logic [31:0]               rx_data,
  output logic                      rx_valid,
  output logic                      busy,
  output logic                      done,
  output logic                      error,
  output logic [31:0]               haddr,
  output logic [1:0]                htrans,
  output logic                      hwrite,
  output logic [2:0]                hsize,
  output logic [31:0]               hwdata,
  input  wire logic [31:0]          hrdata,
  input  wire logic                 hready
);
  import sdbt_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  localparam int LEFT_W = BLK_CNT_W + BLK_WORD_SHIFT;

  if (BLK_CNT_W < 1 || BLK_CNT_W > 16) begin : g_bad_width
    $error("BLK_CNT_W must lie between 1 and 16");
  end

  typedef struct packed {
    sdbt_state_t          st;
    sdbt_phase_t          ph;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [31:0]          hwdata;
    logic                 dir_wr;
    logic                 dma;
    logic                 thr;
    logic [1:0]           width;
    logic                 autoc;
    logic [BLK_CNT_W-1:0] blocks;
    logic [31:0]          cmd;
    logic [31:0]          arg;
    logic [LEFT_W-1:0]    left;
    logic [3:0]           cnt;
    logic                 busy;
    logic                 done;
    logic                 err;
    logic [31:0]          rx_data;
    logic                 rx_valid;
  } sdbt_regs_t;

  sdbt_regs_t  q_reg;
  sdbt_regs_t  q_next;
  logic        go;
  logic [31:0] acc_addr;
  logic        acc_wr;
  logic [31:0] acc_data;
  logic        fin;
  logic [3:0]  chunk;

  assign fin   = (q_reg.ph == PH_DATA) && hready;
  // the threshold bit picks how many words one service moves
  assign chunk = q_reg.thr ? CHUNK32_WORDS : CHUNK16_WORDS;

  always_comb begin
    q_next          = q_reg;
    q_next.done     = 1'b0;
    q_next.rx_valid = 1'b0;
    go              = 1'b0;
    acc_addr        = OFF_ST0;
    acc_wr          = 1'b0;
    acc_data        = 32'h0000_0000;
    tx_ready        = 1'b0;

    if (q_reg.ph == PH_ADDR && hready) begin
      q_next.ph     = PH_DATA;
      q_next.htrans = HTRANS_IDLE;
    end
    if (fin) begin
      q_next.ph = PH_IDLE;
    end

    case (q_reg.st)
      S_IDLE: begin
        if (start) begin
          q_next.dir_wr = cfg_write;
          q_next.dma    = cfg_dma;
          q_next.thr    = cfg_threshold;
          q_next.width  = cfg_width;
          q_next.autoc  = cfg_auto_count;
          q_next.blocks = cfg_blocks;
          q_next.cmd    = cfg_command;
          q_next.arg    = {arg_high, arg_low};
          q_next.left   = LEFT_W'(cfg_blocks) << BLK_WORD_SHIFT;
          q_next.busy   = 1'b1;
          q_next.err    = 1'b0;
          q_next.st     = S_CLR;
          if (cfg_blocks == '0) begin
            q_next.err = 1'b1;
            q_next.st  = S_FIN;
          end
        end
      end
      S_CLR: begin
        go       = 1'b1;
        acc_addr = OFF_FIFOCTL;
        acc_wr   = 1'b1;
        acc_data = 32'h0000_0001 << FC_CLEAR_BIT;
        if (fin) begin
          q_next.st = S_CFG;
        end
      end
      S_CFG: begin
        go       = 1'b1;
        acc_addr = OFF_FIFOCTL;
        acc_wr   = 1'b1;
        acc_data[FC_DIR_BIT] = q_reg.dir_wr;
        acc_data[FC_THR_BIT] = q_reg.thr;
        acc_data[FC_WIDTH_LSB +: 2] = q_reg.width;
        if (fin) begin
          q_next.st = S_BLEN;
        end
      end
      S_BLEN: begin
        go       = 1'b1;
        acc_addr = OFF_BLEN;
        acc_wr   = 1'b1;
        acc_data = BLOCK_BYTES;
        if (fin) begin
          q_next.st = S_NBLK;
        end
      end
      S_NBLK: begin
        go       = 1'b1;
        acc_addr = OFF_NBLK;
        acc_wr   = 1'b1;
        // zero lets the card run on until the stop command
        acc_data = q_reg.autoc ? 32'(q_reg.blocks) : 32'h0000_0000;
        if (fin) begin
          q_next.st = S_IM;
        end
      end
      S_IM: begin
        go       = 1'b1;
        acc_addr = OFF_IM;
        acc_wr   = 1'b1;
        if (!q_reg.dma) begin
          acc_data[ST_TXRDY_BIT] = q_reg.dir_wr;
          acc_data[ST_RXRDY_BIT] = !q_reg.dir_wr;
        end
        if (fin) begin
          q_next.st = S_ARG;
        end
      end
      S_ARG: begin
        go       = 1'b1;
        acc_addr = OFF_ARG;
        acc_wr   = 1'b1;
        acc_data = q_reg.arg;
        if (fin) begin
          q_next.cnt = 4'h0;
          q_next.st  = (q_reg.dir_wr && !q_reg.dma) ? S_PRE : S_CMD;
        end
      end
      S_PRE: begin
        go       = tx_valid;
        acc_addr = OFF_DXR;
        acc_wr   = 1'b1;
        acc_data = tx_data;
        tx_ready = (q_reg.ph == PH_IDLE);
        if (fin) begin
          q_next.cnt  = q_reg.cnt + 4'h1;
          q_next.left = q_reg.left - LEFT_W'(1);
          if (q_reg.cnt + 4'h1 == PRELOAD_WORDS) begin
            q_next.st = S_CMD;
          end
        end
      end
      S_CMD: begin
        go       = 1'b1;
        acc_addr = OFF_CMD;
        acc_wr   = 1'b1;
        acc_data = q_reg.cmd;
        acc_data[CMD_DMA_BIT] = q_reg.dma && q_reg.dir_wr;
        if (fin) begin
          q_next.st = S_POLL;
        end
      end
      S_POLL: begin
        go = 1'b1;
        if (fin) begin
          q_next.cnt = 4'h0;
          if (q_reg.dir_wr && hrdata[ST_WRITE_CRC_ERROR_FLAG_BIT]) begin
            q_next.err = 1'b1;
            q_next.st  = q_reg.autoc ? S_FIN : S_STOP;
          end else if (q_reg.left == '0 || q_reg.dma) begin
            if (hrdata[ST_DONE_BIT]) begin
              q_next.st = q_reg.autoc ? S_FIN : S_STOP;
            end
          end else if (q_reg.dir_wr && hrdata[ST_TXRDY_BIT]) begin
            q_next.st = S_XFER;
          end else if (!q_reg.dir_wr && hrdata[ST_RXRDY_BIT] &&
                       !hrdata[ST_EMPTY_BIT]) begin
            q_next.st = S_XFER;
          end
        end
      end
      S_XFER: begin
        go       = q_reg.dir_wr ? tx_valid : 1'b1;
        acc_addr = q_reg.dir_wr ? OFF_DXR : OFF_DRR;
        acc_wr   = q_reg.dir_wr;
        acc_data = tx_data;
        tx_ready = q_reg.dir_wr && (q_reg.ph == PH_IDLE);
        if (fin) begin
          q_next.cnt  = q_reg.cnt + 4'h1;
          q_next.left = q_reg.left - LEFT_W'(1);
          if (!q_reg.dir_wr) begin
            q_next.rx_data  = hrdata;
            q_next.rx_valid = 1'b1;
          end
          // a chunk ends at the threshold size or at the last word
          if (q_reg.cnt + 4'h1 == chunk || q_reg.left == LEFT_W'(1)) begin
            q_next.st = S_POLL;
          end
        end
      end
      S_STOP: begin
        go       = 1'b1;
        acc_addr = OFF_CMD;
        acc_wr   = 1'b1;
        acc_data = STOP_CMD_WORD;
        if (fin) begin
          q_next.st = S_FIN;
        end
      end
      S_FIN: begin
        q_next.busy = 1'b0;
        q_next.done = 1'b1;
        q_next.st   = S_IDLE;
      end
      default: begin
        q_next.st = S_IDLE;
      end
    endcase

    // with no data ready the access waits, so nothing is issued half-formed
    if (go && q_reg.ph == PH_IDLE) begin
      q_next.ph     = PH_ADDR;
      q_next.htrans = HTRANS_NONSEQ;
      q_next.haddr  = acc_addr;
      q_next.hwrite = acc_wr;
      q_next.hwdata = acc_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q_reg <= '{st: S_IDLE, ph: PH_IDLE, htrans: HTRANS_IDLE, default: '0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign haddr    = q_reg.haddr;
  assign htrans   = q_reg.htrans;
  assign hwrite   = q_reg.hwrite;
  assign hsize    = HSIZE_WORD;
  assign hwdata   = q_reg.hwdata;
  assign rx_data  = q_reg.rx_data;
  assign rx_valid = q_reg.rx_valid;
  assign busy     = q_reg.busy;
  assign done     = q_reg.done;
  assign error    = q_reg.err;

  sequence addr_waits;
    htrans == HTRANS_NONSEQ && !hready;
  endsequence

  a_addr_hold: assert property (addr_waits |=>
    htrans == HTRANS_NONSEQ && $stable(haddr) && $stable(hwrite) &&
    $stable(hwdata))
    else $error("address phase dropped before hready");

  a_fifo_clear: assert property (
    q_reg.st == S_CLR && htrans == HTRANS_NONSEQ |->
      haddr == OFF_FIFOCTL && hwrite && hwdata[FC_CLEAR_BIT])
    else $error("fifo clear write malformed");

  a_dir_width: assert property (
    q_reg.st == S_CFG && q_reg.ph == PH_DATA |->
      hwdata[FC_DIR_BIT] == q_reg.dir_wr && hwdata[FC_THR_BIT] == q_reg.thr &&
      hwdata[FC_WIDTH_LSB +: 2] == q_reg.width)
    else $error("fifo direction or width wrong");

  a_cfg_order: assert property (
    q_reg.st == S_CLR && fin |=> q_reg.st == S_CFG)
    else $error("configuration did not follow fifo clear");

  a_blk_len: assert property (
    q_reg.st == S_BLEN && q_reg.ph == PH_DATA |-> hwdata == BLOCK_BYTES)
    else $error("block length not 512 bytes");

  a_arg_split: assert property (
    q_reg.st == S_ARG && q_reg.ph == PH_DATA |-> haddr == OFF_ARG &&
      hwdata[31:ARG_HIGH_LSB] == q_reg.arg[31:ARG_HIGH_LSB])
    else $error("argument halves misplaced");

  a_preload: assert property (
    q_reg.st == S_CMD && q_reg.dir_wr && !q_reg.dma |->
      q_reg.cnt == PRELOAD_WORDS)
    else $error("write command before 32 byte preload");

  a_chunk_size: assert property (
    q_reg.st == S_XFER && fin && q_next.st == S_POLL |=>
      q_reg.cnt == chunk)
    else $error("chunk ended at wrong size");

  a_rx_word: assert property (
    q_reg.st == S_XFER && !q_reg.dir_wr && fin |=>
      rx_valid && rx_data == $past(hrdata))
    else $error("received word not delivered");

  a_stop_cmd: assert property (
    q_reg.st == S_STOP && q_reg.ph == PH_DATA |->
      !q_reg.autoc && haddr == OFF_CMD && hwdata == STOP_CMD_WORD)
    else $error("stop command wrong or unneeded");

  a_dma_trig: assert property (
    q_reg.st == S_CMD && q_reg.ph == PH_DATA |->
      hwdata[CMD_DMA_BIT] == (q_reg.dma && q_reg.dir_wr))
    else $error("dma trigger bit wrong");

  a_done_end: assert property (
    q_reg.st == S_FIN |=> done && !busy ##1 !done)
    else $error("done pulse malformed");

endmodule
`default_nettype wire

// [sim/sdbt_dev_model.sv]
// behavioural card controller register model answering the host over ahb
`timescale 1ns/1ps
`default_nettype none
module sdbt_dev_model
  import sdbt_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hready,
  input  wire logic        slow,
  input  wire logic        crc_inj,
  input  wire logic [15:0] total
);
  logic [31:0] fc_q, blen_q, nblk_q, im_q, arg_q, cmd_q, sum, noise, st;
  logic [15:0] moved, run, polls, pre_cnt, viol, bad_chunk;
  logic [11:0] st_last;
  logic [7:0]  da;
  logic        dw, dv, going, cleared, clr_at_cmd, stop_seen, avail;
  wire         cpu    = im_q[ST_TXRDY_BIT] | im_q[ST_RXRDY_BIT];
  wire         dir_tx = fc_q[FC_DIR_BIT];
  wire  [15:0] chunk  = fc_q[FC_THR_BIT] ? 16'h0008 : 16'h0004;

  always_comb begin
    st = 32'h0000_0000;
    if (going) begin
      st[ST_DONE_BIT]  = cpu ? (moved == total) : (polls >= 16'h0003);
      st[ST_WRITE_CRC_ERROR_FLAG_BIT] = dir_tx && crc_inj;
      st[ST_TXRDY_BIT] = cpu && dir_tx && avail && moved != total;
      st[ST_RXRDY_BIT] = cpu && !dir_tx && avail && moved != total;
      st[ST_EMPTY_BIT] = !st[ST_RXRDY_BIT];
    end
  end

  // outside a read data phase the bus shows a changing pattern, not old data
  assign hrdata = !(dv && !dw) ? noise : (da == OFF_ST0[7:0]) ? st :
                  (da == OFF_DRR[7:0]) ? {~moved, moved} : 32'h0000_0000;

  always @(posedge sys_clk) begin
    noise <= {noise[30:0], ~(noise[31] ^ noise[21])};
    hready <= slow ? (($urandom % 3) != 0) : 1'h1;
    if (!rst_b) begin
      {dv, going, cleared, clr_at_cmd, stop_seen} <= 5'h00;
      {fc_q, im_q, moved, polls, viol, bad_chunk} <= '0;
      avail <= 1'h1;
      noise <= 32'h1234_5678;
    end else if (hready) begin
      if (dv && dw) begin
        case (da)
          OFF_FIFOCTL[7:0]: begin
            fc_q <= hwdata;
            if (hwdata[FC_CLEAR_BIT]) begin
              {going, stop_seen} <= 2'h0;
              cleared <= 1'h1;
              {moved, run, polls, pre_cnt, viol, bad_chunk, sum} <= '0;
            end
          end
          OFF_BLEN[7:0]: blen_q <= hwdata;
          OFF_NBLK[7:0]: nblk_q <= hwdata;
          OFF_IM[7:0]:   im_q <= hwdata;
          OFF_ARG[7:0]:  arg_q <= hwdata;
          OFF_DXR[7:0]: begin
            sum <= sum + hwdata;
            moved <= moved + 16'h0001;
            if (!going)
              pre_cnt <= pre_cnt + 16'h0001;
            else begin
              run <= run + 16'h0001;
              if (!st_last[ST_TXRDY_BIT]) viol <= viol + 16'h0001;
            end
          end
          OFF_CMD[7:0]: begin
            if (hwdata == STOP_CMD_WORD)
              stop_seen <= 1'h1;
            else begin
              cmd_q <= hwdata;
              going <= 1'h1;
              clr_at_cmd <= cleared;
              cleared <= 1'h0;
              st_last <= 12'h000;
            end
          end
          default: ;
        endcase
      end
      if (dv && !dw && da == OFF_ST0[7:0]) begin
        st_last <= st[11:0];
        polls <= polls + 16'h0001;
        if (run != 16'h0000 && run != chunk) begin
          bad_chunk <= bad_chunk + 16'h0001;
        end
        run <= 16'h0000;
        avail <= slow ? 1'($urandom) : 1'h1;
      end
      if (dv && !dw && da == OFF_DRR[7:0]) begin
        moved <= moved + 16'h0001;
        run <= run + 16'h0001;
        if (st_last[ST_EMPTY_BIT]) viol <= viol + 16'h0001;
      end
      dv <= htrans == HTRANS_NONSEQ;
      da <= haddr[7:0];
      dw <= hwrite;
    end
  end
endmodule
`default_nettype wire

// [sim/sdbt_host_tb.sv]
// self-checking bench for the card block-transfer host sequencer
`timescale 1ns/1ps
`default_nettype none
module sdbt_host_tb;
  import sdbt_pkg::*;
  logic        sys_clk, rst_b, start, cfg_write, cfg_dma, cfg_threshold;
  logic        cfg_auto_count, tx_valid, tx_ready, rx_valid, busy, done;
  logic        error, hwrite, hready, slow, crc_inj;
  logic [1:0]  cfg_width, htrans;
  logic [2:0]  hsize;
  logic [15:0] cfg_blocks, arg_high, arg_low, total, tx_idx, rx_idx;
  logic [31:0] cfg_command, tx_data, hrdata, haddr, hwdata, rx_data, salt;
  int          mismatches, check_count;

  sdbt_host #(.BLK_CNT_W(16)) dut (.sys_clk, .rst_b, .start, .cfg_write,
    .cfg_dma, .cfg_threshold, .cfg_width, .cfg_auto_count, .cfg_blocks,
    .cfg_command, .arg_high, .arg_low, .tx_data, .tx_valid, .tx_ready,
    .rx_data, .rx_valid, .busy, .done, .error, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hrdata, .hready);
  sdbt_dev_model dev (.sys_clk, .rst_b, .haddr, .htrans, .hwrite, .hwdata,
    .hrdata, .hready, .slow, .crc_inj, .total);

  function automatic logic [31:0] txw(input logic [15:0] k);
    return {k, ~k} ^ salt;
  endfunction
  function automatic logic [31:0] tx_sum(input logic [15:0] n);
    logic [31:0] s;
    s = 32'h0000_0000;
    for (int k = 0; k < n; k++) s = s + txw(16'(k));
    return s;
  endfunction
  function automatic logic [31:0] mask_exp(input logic w, input logic d);
    if (d) return 32'h0000_0000;
    return w ? 32'h0000_0200 : 32'h0000_0400;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // stream side: random gaps on tx, every rx word checked in order
  always @(posedge sys_clk) begin
    tx_valid <= ($urandom % 4) != 0;
    if (start) begin
      tx_idx <= 16'h0000;
      tx_data <= txw(16'h0000);
      rx_idx <= 16'h0000;
    end else begin
      if (tx_valid && tx_ready) begin
        tx_idx <= tx_idx + 16'h0001;
        tx_data <= txw(tx_idx + 16'h0001);
      end
      if (rx_valid) begin
        chk(rx_data, {~rx_idx, rx_idx}, "rx word");
        rx_idx <= rx_idx + 16'h0001;
      end
    end
  end

  task automatic xfer(input logic w, d, t, a, c, input logic [15:0] b);
    int n;
    @(posedge sys_clk);
    {cfg_write, cfg_dma, cfg_threshold, cfg_auto_count} <= {w, d, t, a};
    cfg_width <= 2'($urandom);
    cfg_blocks <= b;
    total <= b << BLK_WORD_SHIFT;
    cfg_command <= ($urandom & 32'hFFFE_FFFF) | 32'h0000_0100;
    arg_high <= 16'($urandom);
    arg_low <= 16'($urandom);
    salt <= $urandom;
    slow <= 1'($urandom);
    crc_inj <= c;
    start <= 1'h1;
    @(posedge sys_clk);
    start <= 1'h0;
    #1 chk(32'(busy), 32'h0000_0001, "busy");
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (done !== 1'h1 && n < 30000);
    chk(32'(n < 30000), 32'h0000_0001, "done");
    chk(32'(hsize), 32'(HSIZE_WORD), "hsize");
    if (b == 16'h0000) begin
      chk(32'(error), 32'h0000_0001, "zero blocks refused");
      return;
    end
    chk(32'(error), 32'(c), "crc error");
    chk(32'(dev.clr_at_cmd), 32'h0000_0001, "clear");
    chk(32'(dev.fc_q[FC_DIR_BIT]), 32'(w), "dir");
    chk(32'(dev.fc_q[FC_THR_BIT]), 32'(t), "thr");
    chk(32'(dev.fc_q[FC_WIDTH_LSB +: 2]), 32'(cfg_width), "width");
    chk(dev.blen_q, BLOCK_BYTES, "blen");
    chk(dev.nblk_q, a ? 32'(b) : 32'h0000_0000, "nblk");
    chk(32'(dev.stop_seen), 32'(!a), "stop");
    chk(dev.arg_q, {arg_high, arg_low}, "arg");
    chk(dev.cmd_q, cfg_command | (32'(d && w) << CMD_DMA_BIT), "cmd");
    chk(dev.im_q, mask_exp(w, d), "mask");
    chk(32'(dev.viol), 32'h0000_0000, "ready flag");
    chk(32'(dev.bad_chunk), 32'h0000_0000, "chunk");
    if (!d && !c) begin
      chk(32'(dev.moved), 32'(total), "words");
      if (w) begin
        chk(dev.sum, tx_sum(total), "tx sum");
        chk(32'(dev.pre_cnt), 32'(PRELOAD_WORDS), "preload");
      end else
        chk(32'(rx_idx), 32'(total), "rx count");
    end
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #900000;
    mismatches++;
    close_out;
  end

  initial begin
    void'($urandom(32'hc301_cfbc));
    {rst_b, start, cfg_write, cfg_dma, cfg_threshold, cfg_auto_count} = '0;
    {tx_valid, slow, crc_inj, cfg_width, cfg_blocks, arg_high} = '0;
    {arg_low, total, cfg_command, tx_data, salt, tx_idx, rx_idx} = '0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'h1;
    // every mode combination: direction, dma, threshold, counted or stopped
    for (int i = 0; i < 16; i++)
      xfer(i[0], i[1], i[2], i[3], 1'h0, 16'(1 + $urandom % 2));
    xfer(1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 16'h0001);
    xfer(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 16'h0002);
    // a zero block count is refused with an error and no bus traffic
    xfer(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 16'h0000);
    close_out;
  end
endmodule
`default_nettype wire
